/* File: hdl/output_sync_digital_delay.v */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sync_delay_consts.vh"
// What this block does
// - Sync assertion is captured on a rising edge; outputs go low 6 cycles later.
// - Outputs rise 6 cycles plus their delay count after release capture.
// - Delay count below 5 acts as 5, so earliest rise is 11 cycles.
// - Half-step set with delay 5 gives a rise at 10 cycles.
// - Both outputs of one group share one circuit and always match.
// - Qualify enable makes each sync wait for a selected output clock.
// - The qualifying clock is the group named by the qualifier select field.
// - Exempt groups keep toggling through every sync event.
// - Half-step changes shift a group's second outputs by one cycle at once.
// - A new delay count takes effect only at the next sync event.
// - With auto resync on, writing any group register starts a sync.
// - Without auto resync, sync comes from polarity toggle or the sync input.
// - Qualified sync makes a 3-cycle one-shot starting 3 cycles later.
// - Qualified restart is a fixed delay from the qualifier falling edge.
// - Non-exempt groups are held low while sync is active.
// - Exempt groups are completely unaffected by sync events.

module output_sync_digital_delay (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        sync_pin,
	output wire [11:0] out_first,
	output wire [11:0] out_second
);

	// ------------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------------
	reg  [`SD_CTRL_W-1:0] ctrl_r;
	reg  [31:0]           prdata_r;
	reg  [31:0]           rd_val;
	wire                  mapped;
	wire                  wr_en;
	wire                  grp_wr;
	wire [59:0]           cfg_all;
	wire [5:0]            held_all;
	wire [5:0]            w_all;
	wire [5:0]            o_all;

	// Misaligned or out-of-range addresses only raise pslverr; they never write.
	assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= `SD_OFF_STAT);
	assign wr_en   = psel && penable && pwrite && mapped;
	assign grp_wr  = wr_en && (paddr <= `SD_OFF_GRP_LAST);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_r;

	wire                  qual_en   = ctrl_r[`SD_F_QUAL_EN];
	wire [2:0]            qual_sel  = ctrl_r[`SD_F_QSEL_HI:`SD_F_QSEL_LO];
	wire                  auto_en   = ctrl_r[`SD_F_AUTO_EN];
	wire                  pol_inv   = ctrl_r[`SD_F_POL_INV];
	wire                  pd_four   = ctrl_r[`SD_F_PD4];
	wire                  qpath_en  = ctrl_r[`SD_F_QPATH_EN];

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_r <= `SD_CTRL_RST;
		end else if (wr_en && paddr == `SD_OFF_CTRL) begin
			ctrl_r <= pwdata[`SD_CTRL_W-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Sync request capture
	// ------------------------------------------------------------------------
	reg        s1_r;
	reg        s2_r;
	reg        cap_r;
	reg  [1:0] auto_r;
	reg  [2:0] acnt_r;
	reg        pend_r;
	reg  [2:0] qcnt_r;
	reg        os_r;
	wire       req;
	wire       cap_rise;
	wire       cap_fall;
	wire       q_ok;
	wire       q_fall;
	wire       off_go;
	wire       rel_go;

	// A polarity toggle flips the request level, so it alone starts a sync.
	assign req      = (s2_r ^ pol_inv) | (auto_r != 2'h0);
	assign cap_rise = req && !cap_r;
	assign cap_fall = !req && cap_r;

	// A stopped qualifier path or a select past the last group never qualifies.
	// Qualifier falls at the edge where its lookahead is low and output high.
	assign q_ok   = qpath_en && (qual_sel <= `SD_QSEL_MAX);
	assign q_fall = q_ok && o_all[qual_sel] && !w_all[qual_sel];

	// In qualified mode the one-shot times both the stop and the restart.
	assign off_go = qual_en ? (qcnt_r == `SD_OS_FIRST) : (acnt_r == 3'h1);
	assign rel_go = qual_en ? (qcnt_r == `SD_OS_END) : cap_fall;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			s1_r   <= 1'b0;
			s2_r   <= 1'b0;
			cap_r  <= 1'b0;
			auto_r <= 2'h0;
			acnt_r <= 3'h0;
			pend_r <= 1'b0;
			qcnt_r <= 3'h0;
			os_r   <= 1'b0;
		end else begin
			s1_r  <= sync_pin;
			s2_r  <= s1_r;
			cap_r <= req;
			// A register-made request lasts several cycles, as a pin request must.
			if (grp_wr && auto_en) begin
				auto_r <= `SD_AUTO_LEN;
			end else if (auto_r != 2'h0) begin
				auto_r <= auto_r - 2'h1;
			end
			// The stop lands six edges after capture: five counts, then the output flop.
			if (cap_rise && !qual_en) begin
				acnt_r <= `SD_ASSERT_LOAD;
			end else if (acnt_r != 3'h0) begin
				acnt_r <= acnt_r - 3'h1;
			end
			if (qual_en && pend_r && qcnt_r == 3'h0 && q_fall) begin
				pend_r <= 1'b0;
			end else if (qual_en && cap_rise) begin
				pend_r <= 1'b1;
			end else if (!qual_en) begin
				pend_r <= 1'b0;
			end
			if (qual_en && pend_r && qcnt_r == 3'h0 && q_fall) begin
				qcnt_r <= 3'h1;
			end else if (qcnt_r == `SD_OS_END) begin
				qcnt_r <= 3'h0;
			end else if (qcnt_r != 3'h0) begin
				qcnt_r <= qcnt_r + 3'h1;
			end
			os_r <= (qcnt_r >= `SD_OS_FIRST) && (qcnt_r <= `SD_OS_LAST);
		end
	end

	// ------------------------------------------------------------------------
	// Output groups
	// ------------------------------------------------------------------------
	// Each group runs one step ahead in w_r so the half-step output can show
	// the next value in the second half of a cycle without a second clock.
	genvar g;
	generate
		for (g = 0; g < `SD_GROUPS; g = g + 1) begin : grp
			// Byte address of this group's configuration word.
			localparam integer GOFF_I = 4 * g;
			localparam [7:0]   GOFF   = GOFF_I[7:0];
			reg  [`SD_GRP_W-1:0] cfg_r;
			reg  [4:0]           dly_r;
			reg  [5:0]           rcnt_r;
			reg                  held_r;
			reg                  w_r;
			reg                  o_r;
			reg                  div_r;
			reg  [4:0]           dly_nxt;
			reg  [5:0]           rcnt_nxt;
			reg                  held_nxt;
			reg                  w_nxt;
			reg                  div_nxt;
			wire [4:0]           dly_req;
			wire [4:0]           dly_eff;
			wire                 exempt;
			wire                 half;
			wire                 pd;

			assign dly_req = cfg_r[`SD_F_DLY_HI:`SD_F_DLY_LO];
			assign dly_eff = (dly_req < `SD_MIN_DLY) ? `SD_MIN_DLY : dly_req;
			assign exempt  = cfg_r[`SD_F_EXEMPT];
			assign half    = cfg_r[`SD_F_HALF];
			assign pd      = (g == 2) && pd_four;

			always @* begin
				dly_nxt  = dly_r;
				rcnt_nxt = rcnt_r;
				held_nxt = held_r;
				w_nxt    = w_r;
				div_nxt  = div_r;
				if (held_r) begin
					w_nxt   = 1'b0;
					div_nxt = 1'b0;
				end else if (div_r == `SD_DIV_HALF) begin
					w_nxt   = !w_r;
					div_nxt = 1'b0;
				end else begin
					div_nxt = 1'b1;
				end
				// Exempt groups drop any hold or pending restart and simply run on.
				if (exempt) begin
					held_nxt = 1'b0;
					rcnt_nxt = 6'h00;
				end else begin
					if (off_go) begin
						held_nxt = 1'b1;
						w_nxt    = 1'b0;
					end
					// The load is one short of 6 plus the delay because o_r trails w_r by a cycle.
					if (rel_go) begin
						dly_nxt  = dly_eff;
						rcnt_nxt = `SD_REL_LOAD + {1'b0, dly_eff};
					end else if (cap_rise && !qual_en) begin
						// A new request outside qualified mode drops a restart still counting, so it cannot end the hold early.
						rcnt_nxt = 6'h00;
					end else if (rcnt_r == 6'h01) begin
						held_nxt = 1'b0;
						w_nxt    = 1'b1;
						div_nxt  = 1'b0;
						rcnt_nxt = 6'h00;
					end else if (rcnt_r != 6'h00) begin
						rcnt_nxt = rcnt_r - 6'h01;
					end
				end
			end

			always @(posedge sys_clk) begin
				if (!rst_n) begin
					cfg_r  <= `SD_GRP_RST;
					dly_r  <= `SD_MIN_DLY;
					rcnt_r <= 6'h00;
					held_r <= 1'b0;
					w_r    <= 1'b0;
					o_r    <= 1'b0;
					div_r  <= 1'b0;
				end else begin
					if (wr_en && paddr == GOFF) begin
						cfg_r <= pwdata[`SD_GRP_W-1:0];
					end
					dly_r  <= dly_nxt;
					rcnt_r <= rcnt_nxt;
					held_r <= held_nxt;
					w_r    <= w_nxt;
					o_r    <= w_r;
				end
				if (rst_n) begin
					div_r <= div_nxt;
				end
			end

			assign cfg_all[g*10 +: 10] = cfg_r;
			assign held_all[g]         = held_r;
			assign w_all[g]            = w_r;
			assign o_all[g]            = o_r;
			// Both outputs of a group come from the same flops, so they match.
			assign out_first[2*g]      = o_r && !pd;
			assign out_first[2*g+1]    = o_r && !pd;
			assign out_second[2*g]     = (half ? w_r : o_r) && !pd;
			assign out_second[2*g+1]   = (half ? w_r : o_r) && !pd;
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------------
	always @* begin
		rd_val = 32'h00000000;
		if (paddr <= `SD_OFF_GRP_LAST) begin
			rd_val[`SD_GRP_W-1:0] = cfg_all[paddr[4:2]*10 +: 10];
		end else if (paddr == `SD_OFF_CTRL) begin
			rd_val[`SD_CTRL_W-1:0] = ctrl_r;
		end else if (paddr == `SD_OFF_STAT) begin
			rd_val[0]     = cap_r;
			rd_val[1]     = pend_r;
			rd_val[2]     = os_r;
			rd_val[13:8]  = held_all;
			rd_val[21:16] = o_all;
		end
	end

	// Read data is taken in the setup cycle, so it stands through the access phase.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata_r <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= mapped ? rd_val : 32'h00000000;
		end
	end

endmodule // output_sync_digital_delay
`default_nettype wire

/* File: pkg/sync_delay_consts.vh */
`ifndef SYNC_DELAY_CONSTS_VH
`define SYNC_DELAY_CONSTS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define SD_OFF_GRP0      8'h00
`define SD_OFF_GRP_LAST  8'h14
`define SD_OFF_CTRL      8'h18
`define SD_OFF_STAT      8'h1C
`define SD_GROUPS        6

// ----------------------------------------------------------------------------
// Group configuration fields
// ----------------------------------------------------------------------------
`define SD_F_DLY_HI      4
`define SD_F_DLY_LO      0
`define SD_F_HALF        8
`define SD_F_EXEMPT      9
`define SD_GRP_W         10
`define SD_GRP_RST       10'h005

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define SD_F_QUAL_EN     0
`define SD_F_QSEL_HI     3
`define SD_F_QSEL_LO     1
`define SD_F_AUTO_EN     4
`define SD_F_POL_INV     5
`define SD_F_PD4         6
`define SD_F_QPATH_EN    7
`define SD_CTRL_W        8
`define SD_CTRL_RST      8'h00
`define SD_QSEL_MAX      3'h5

// ----------------------------------------------------------------------------
// Timing counts in distribution-path cycles
// ----------------------------------------------------------------------------
`define SD_ASSERT_LOAD   3'h5
`define SD_REL_LOAD      6'h05
`define SD_MIN_DLY       5'h05
`define SD_OS_FIRST      3'h3
`define SD_OS_LAST       3'h5
`define SD_OS_END        3'h6
`define SD_AUTO_LEN      2'h3
`define SD_DIV_HALF      1'b1

`endif

/* File: sim/output_sync_digital_delay_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module output_sync_digital_delay_tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        slv_err;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         sync_pin;
	wire  [11:0] out_first;
	wire  [11:0] out_second;
	int          n_errors = 0;
	int          comparisons = 0;

	always #4 sys_clk = ~sys_clk;

	output_sync_digital_delay i_output_sync_digital_delay (.sys_clk(sys_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sync_pin(sync_pin), .out_first(out_first), .out_second(out_second));
	sync_host i_sync_host (.sys_clk(sys_clk), .sync_pin(sync_pin));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata;
		slv_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Counts edges until the chosen output bit is high; it must start low.
	task automatic rise(input int b, input logic sec, input int exp, input string name);
		int n;
		logic v;
		n = 0;
		v = 1'b0;
		while (v !== 1'b1 && n < 64) begin
			@(posedge sys_clk);
			#1;
			n++;
			v = sec ? out_second[b] : out_first[b];
		end
		chk(name, 32'(exp), 32'(n));
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] rd;
		for (int g = 0; g < 6; g++) begin
			apb(1'b0, 8'(4 * g), 32'h0, rd);
			chk("group reset", 32'h0000_0005, rd);
		end
		apb(1'b0, 8'h18, 32'h0, rd);
		chk("control reset", 32'h0, rd);
		apb(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
		chk("unmapped error", 32'h1, 32'(slv_err));
		apb(1'b0, 8'h21, 32'h0, rd);
		chk("misaligned read", 32'h0, rd);
		apb(1'b1, 8'h00, 32'h0000_0105, rd);
		apb(1'b1, 8'h04, 32'h0000_0008, rd);
		apb(1'b1, 8'h0C, 32'h0000_0205, rd);
		apb(1'b0, 8'h04, 32'h0, rd);
		chk("group readback", 32'h0000_0008, rd);
	endtask

	task automatic t_pin;
		i_sync_host.drive(1'b1);
		repeat (9) @(posedge sys_clk);
		#1;
		for (int i = 0; i < 4; i++) begin
			chk("held low", 32'h0, 32'(out_first[3:0]));
			@(posedge sys_clk);
			#1;
		end
		i_sync_host.drive(1'b0);
		fork
			rise(0, 1'b1, 13, "half step rise");
			rise(0, 1'b0, 14, "minimum rise");
			rise(2, 1'b0, 17, "delay 8 rise");
		join
	endtask

	task automatic t_pol;
		logic [31:0] rd;
		apb(1'b1, 8'h04, 32'h0000_000A, rd);
		apb(1'b1, 8'h18, 32'h0000_0020, rd);
		repeat (12) @(posedge sys_clk);
		#1;
		chk("polarity hold", 32'h0, 32'(out_first[3:2]));
		apb(1'b1, 8'h18, 32'h0000_0000, rd);
		rise(2, 1'b0, 17, "new delay rise");
	endtask

	task automatic t_auto;
		logic [31:0] rd;
		apb(1'b1, 8'h18, 32'h0000_0010, rd);
		apb(1'b1, 8'h04, 32'h0000_0106, rd);
		repeat (10) @(posedge sys_clk);
		#1;
		chk("auto hold", 32'h0, 32'(out_first[3:2]));
		repeat (2) @(posedge sys_clk);
		#1;
		chk("auto hold late", 32'h0, 32'(out_first[3:2]));
	endtask

	// Qualified restart timed from the exempt group 3, an absolute adjustment.
	task automatic t_qual;
		logic [31:0] rd;
		logic        prev;
		int          n;
		apb(1'b1, 8'h18, 32'h0000_0087, rd);
		i_sync_host.drive(1'b1);
		repeat (3) @(posedge sys_clk);
		#1;
		n = 0;
		do begin
			prev = out_first[6];
			@(posedge sys_clk);
			#1;
			n++;
		end while (!(prev === 1'b1 && out_first[6] === 1'b0) && n < 8);
		chk("qualifier fall", 32'h1, 32'(prev === 1'b1 && out_first[6] === 1'b0));
		repeat (2) @(posedge sys_clk);
		apb(1'b0, 8'h1C, 32'h0, rd);
		chk("one-shot status", 32'h0000_3705, rd & 32'h0000_3F07);
		fork
			rise(0, 1'b0, 12, "qualified rise");
			rise(0, 1'b1, 11, "qualified half rise");
		join
		i_sync_host.drive(1'b0);
	endtask

	task automatic end_sim;
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_pin();
		t_pol();
		t_auto();
		t_qual();
		end_sim();
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		n_errors++;
		end_sim();
	end
endmodule // output_sync_digital_delay_tb
`default_nettype wire

/* File: sim/sync_delay_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_delay_checker (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sync_pin,
	input wire logic [11:0] out_first,
	input wire logic [11:0] out_second
);
	logic [7:0]  ctrl_r;
	logic [5:0]  ex_r;
	logic [5:0]  hs_r;
	logic [11:0] exm;
	logic [11:0] hsm;
	logic        acc;
	logic        req;
	logic [3:0]  req_cnt_r;
	assign acc = psel && penable;
	assign req = (sync_pin ^ ctrl_r[5]) && !ctrl_r[0];
	// Counts back-to-back request cycles, saturating, so a long hold needs no repetition.
	always @(posedge sys_clk) begin
		if (!rst_n || !req) begin
			req_cnt_r <= 4'h0;
		end else if (req_cnt_r != 4'hF) begin
			req_cnt_r <= req_cnt_r + 4'h1;
		end
	end
	// Shadows of the fields the checks need, so the checker relies on ports only.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_r <= 8'h00;
			ex_r   <= 6'h00;
			hs_r   <= 6'h00;
		end else if (acc && pwrite) begin
			if (paddr == 8'h18) begin
				ctrl_r <= pwdata[7:0];
			end
			for (int g = 0; g < 6; g++) begin
				if (paddr == 8'(4 * g)) begin
					ex_r[g] <= pwdata[9];
					hs_r[g] <= pwdata[8];
				end
			end
		end
	end
	always_comb begin
		for (int g = 0; g < 6; g++) begin
			exm[2*g+:2] = {2{ex_r[g]}};
			hsm[2*g+:2] = {2{hs_r[g]}};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	pready_on_a: assert property (acc |-> pready) else $error("pready low in access");
	slverr_map_a: assert property (acc && (paddr > 8'h1C || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("no error on unmapped access");
	slverr_idle_a: assert property (!acc |-> !pslverr) else $error("error outside access");
	pair_first_a: assert property (((out_first ^ (out_first >> 1)) & 12'h555) == 12'h000)
		else $error("group pair differs");
	pair_second_a: assert property (((out_second ^ (out_second >> 1)) & 12'h555) == 12'h000)
		else $error("group pair differs in second half");
	hold_low_a: assert property (req && req_cnt_r >= 4'h9 |-> (out_first & ~exm) == 12'h000)
		else $error("output not held low");
	exempt_run_a: assert property (ex_r[3] && $stable(out_first[6]) |=> !$stable(out_first[6]))
		else $error("exempt group stalled");
	auto_sync_a: assert property (acc && pwrite && paddr <= 8'h14 && paddr[1:0] == 2'b00 && ctrl_r[4] && !ctrl_r[0]
		|-> ##[1:16] (out_first & ~exm) == 12'h000) else $error("no sync after group write");
	half_off_a: assert property ((out_second & ~hsm) == (out_first & ~hsm))
		else $error("half step seen with bit clear");
	cover property (req && req_cnt_r == 4'h9);
	cover property (acc && pwrite && ctrl_r[4]);
	cover property (hs_r[0] && $rose(out_second[0]));
endmodule // sync_delay_checker
bind output_sync_digital_delay sync_delay_checker i_sync_delay_checker (.sys_clk(sys_clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sync_pin(sync_pin), .out_first(out_first), .out_second(out_second));
`default_nettype wire

/* File: sim/sync_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_host (
	input  wire logic sys_clk,
	output logic      sync_pin
);
	initial sync_pin = 1'b0;
	// Callers keep each level for several cycles; a one-cycle blip could be missed.
	task automatic drive(input logic v);
		@(posedge sys_clk);
		sync_pin <= v;
	endtask
endmodule // sync_host
`default_nettype wire
